// ==== pair_id_table.v ====
// Request identity table with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "ptp_filter_regs.vh"

module pair_id_table (
    // Clock and reset
    input wire clk_in,
    input wire sys_rst_in,
    input wire ce_in,
    // Read port
    input wire [`PAIR_IDX_W-1:0] rd_idx_in,
    output reg rd_valid_out,
    output reg [`PAIR_KEY_W-1:0] rd_key_out,
    // Write port
    input wire wr_en_in,
    input wire [`PAIR_IDX_W-1:0] wr_idx_in,
    input wire [`PAIR_KEY_W-1:0] wr_key_in
);

    reg [`PAIR_KEY_W-1:0] key_mem [0:`PAIR_DEPTH-1];
    reg [`PAIR_DEPTH-1:0] used_r;

    // Data array, no reset needed
    always @(posedge clk_in) begin
        if (ce_in && wr_en_in) begin
            key_mem[wr_idx_in] <= wr_key_in;
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            used_r <= {`PAIR_DEPTH{1'b0}};
            rd_valid_out <= 1'b0;
            rd_key_out <= {`PAIR_KEY_W{1'b0}};
        end else if (ce_in) begin
            if (wr_en_in) begin
                used_r[wr_idx_in] <= 1'b1;
            end
            rd_valid_out <= used_r[rd_idx_in];
            rd_key_out <= key_mem[rd_idx_in];
        end
    end

endmodule
`default_nettype wire

// ==== ptp_filter_regs.vh ====
// Register map, field positions and message codes of the PTP message filter
`ifndef PTP_FILTER_REGS_VH
`define PTP_FILTER_REGS_VH

// ****************************************************
// Register offsets
// ****************************************************
`define OFS_MSG_CONFIG_TWO 12'h516
`define OFS_DOMAIN_VERSION 12'h518
`define OFS_DROP_COUNT 12'h51c

// ****************************************************
// Reset values and writable masks
// ****************************************************
`define RST_MSG_CONFIG_TWO 16'h1004
`define MASK_MSG_CONFIG_TWO 16'h1fff
`define RST_DOMAIN_VERSION 16'h0200
`define MASK_DOMAIN_VERSION 16'h0fff

// ****************************************************
// Field positions
// ****************************************************
`define BIT_SYNC_PAIR 9
`define BIT_DELAY_PAIR 8
`define BIT_PDELAY_PAIR 7
`define BIT_NO_MASTER_DROP 5
`define BIT_DOMAIN_CHECK 4
`define BIT_CSUM_ENABLE 2
`define VERSION_HI 11
`define VERSION_LO 8
`define DOMAIN_HI 7
`define DOMAIN_LO 0

// ****************************************************
// PTP message type codes
// ****************************************************
`define MT_SYNC 4'h0
`define MT_DELAY_REQ 4'h1
`define MT_PDELAY_REQ 4'h2
`define MT_PDELAY_RESP 4'h3
`define MT_FOLLOW_UP 4'h8
`define MT_DELAY_RESP 4'h9
`define MT_PDELAY_RESP_FU 4'ha

// ****************************************************
// Pairing classes and table shape
// ****************************************************
`define CLS_SYNC 2'h0
`define CLS_DELAY 2'h1
`define CLS_PDELAY 2'h2
`define CLS_NONE 2'h3
`define PAIR_IDX_W 5
`define PAIR_DEPTH 32
`define PAIR_KEY_W 40

`endif

// ==== ptp_message_filter_config.v ====
// PTP message filter: configuration registers, checks and pairing verdicts
// Behaviour
// - Delay pairing enabled: Delay_Resp forwarded to host only if a Delay_Req matches.
// - Pdelay pairing enabled: Pdelay_Resp and its follow-up need a matching Pdelay_Req.
// - No-master drop enabled: drop Sync, Follow_Up, Delay_Req while no master known.
// - Domain check enabled: matching domain goes to host, others are dropped.
// - Checksum enable set (reset default): modified egress frames get a recomputed checksum.
// - Checksum enable clear: modified egress frames get a zero checksum.
// - An IPv4 frame arriving with zero checksum leaves with zero checksum.
// - IPv6/UDP frames always get their checksum updated.
// - Four-bit expected version, reset two; matching versions are captured.
// - Messages with a version other than the expected one are dropped.
// - Eight-bit expected domain, reset zero, gates timestamp capture when checked.
// - Domain check disabled: the received domain field is ignored, except that it stays part of the pairing key.
// - Sync pairing enabled: Follow_Up forwarded to host only if a Sync matches.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ptp_filter_regs.vh"

module ptp_message_filter_config (
    // Clock, reset, enable
    input wire clk_in,
    input wire sys_rst_in,
    input wire ce_in,
    // Register port
    input wire [11:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [15:0] reg_rdata_out,
    // Best master clock state
    input wire bmc_known_in,
    // Parsed message header
    input wire msg_valid_in,
    input wire [3:0] msg_type_in,
    input wire [3:0] msg_version_in,
    input wire [7:0] msg_domain_in,
    input wire [15:0] msg_seq_in,
    input wire [15:0] msg_src_port_in,
    // Egress checksum data
    input wire msg_is_ipv6_in,
    input wire msg_modified_in,
    input wire [15:0] msg_csum_in,
    input wire [15:0] msg_old_word_in,
    input wire [15:0] msg_new_word_in,
    // Verdict
    output reg verdict_valid_out,
    output reg fwd_host_out,
    output reg drop_out,
    output reg ts_capture_out,
    output wire [15:0] csum_out
);

    // ****************************************************
    // Helper functions
    // ****************************************************
    // Pairing class of a message
    function [1:0] msg_class;
        input [3:0] t;
        begin
            case (t)
                `MT_SYNC, `MT_FOLLOW_UP: msg_class = `CLS_SYNC;
                `MT_DELAY_REQ, `MT_DELAY_RESP: msg_class = `CLS_DELAY;
                `MT_PDELAY_REQ, `MT_PDELAY_RESP, `MT_PDELAY_RESP_FU: msg_class = `CLS_PDELAY;
                default: msg_class = `CLS_NONE;
            endcase
        end
    endfunction

    // Table slot from class and low sequence bits
    function [`PAIR_IDX_W-1:0] pair_index;
        input [3:0] t;
        input [15:0] seq;
        begin
            pair_index = {msg_class(t), seq[2:0]};
        end
    endfunction

    // ****************************************************
    // Configuration registers
    // ****************************************************
    reg [15:0] config_two_r;
    reg [15:0] domain_version_r;
    reg [15:0] drop_count_r;
    reg [15:0] rdata_nxt;

    wire sync_pair_en = config_two_r[`BIT_SYNC_PAIR];
    wire delay_pair_en = config_two_r[`BIT_DELAY_PAIR];
    wire pdelay_pair_en = config_two_r[`BIT_PDELAY_PAIR];
    wire no_master_drop_en = config_two_r[`BIT_NO_MASTER_DROP];
    wire domain_check_en = config_two_r[`BIT_DOMAIN_CHECK];
    wire csum_enable = config_two_r[`BIT_CSUM_ENABLE];
    wire [3:0] expected_version = domain_version_r[`VERSION_HI:`VERSION_LO];
    wire [7:0] expected_domain_number = domain_version_r[`DOMAIN_HI:`DOMAIN_LO];

    // Read-only upper bits stay zero through the masks
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            config_two_r <= `RST_MSG_CONFIG_TWO;
            domain_version_r <= `RST_DOMAIN_VERSION;
        end else if (ce_in && reg_wr_in) begin
            if (reg_addr_in == `OFS_MSG_CONFIG_TWO) begin
                config_two_r <= reg_wdata_in & `MASK_MSG_CONFIG_TWO;
            end
            if (reg_addr_in == `OFS_DOMAIN_VERSION) begin
                domain_version_r <= reg_wdata_in & `MASK_DOMAIN_VERSION;
            end
        end
    end

    // Read data for one cycle only, zero for unmapped offsets
    always @* begin
        rdata_nxt = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `OFS_MSG_CONFIG_TWO: rdata_nxt = config_two_r;
                `OFS_DOMAIN_VERSION: rdata_nxt = domain_version_r;
                `OFS_DROP_COUNT: rdata_nxt = drop_count_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (ce_in) begin
            reg_rdata_out <= rdata_nxt;
        end
    end

    // ****************************************************
    // Stage 1: header held while the table is read
    // ****************************************************
    reg s1_valid_r;
    reg [3:0] s1_type_r;
    reg [3:0] s1_version_r;
    reg [7:0] s1_domain_r;
    reg [15:0] s1_seq_r;
    reg [15:0] s1_src_r;

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s1_valid_r <= 1'b0;
            s1_type_r <= 4'h0;
            s1_version_r <= 4'h0;
            s1_domain_r <= 8'h00;
            s1_seq_r <= 16'h0000;
            s1_src_r <= 16'h0000;
        end else if (ce_in) begin
            s1_valid_r <= msg_valid_in;
            if (msg_valid_in) begin
                s1_type_r <= msg_type_in;
                s1_version_r <= msg_version_in;
                s1_domain_r <= msg_domain_in;
                s1_seq_r <= msg_seq_in;
                s1_src_r <= msg_src_port_in;
            end
        end
    end

    // ****************************************************
    // Pairing table
    // ****************************************************
    wire tbl_valid;
    wire [`PAIR_KEY_W-1:0] tbl_key;
    wire [`PAIR_KEY_W-1:0] s1_key = {s1_domain_r, s1_seq_r, s1_src_r};
    reg is_request;
    reg is_response;
    reg pair_enabled;
    reg tbl_wr;

    pair_id_table u_pair_table (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .rd_idx_in(pair_index(msg_type_in, msg_seq_in)),
        .rd_valid_out(tbl_valid),
        .rd_key_out(tbl_key),
        .wr_en_in(tbl_wr),
        .wr_idx_in(pair_index(s1_type_r, s1_seq_r)),
        .wr_key_in(s1_key)
    );

    always @* begin
        is_request = 1'b0;
        is_response = 1'b0;
        pair_enabled = 1'b0;
        case (s1_type_r)
            `MT_SYNC: is_request = 1'b1;
            `MT_DELAY_REQ: is_request = 1'b1;
            `MT_PDELAY_REQ: is_request = 1'b1;
            `MT_FOLLOW_UP: begin
                is_response = 1'b1;
                pair_enabled = sync_pair_en;
            end
            `MT_DELAY_RESP: begin
                is_response = 1'b1;
                pair_enabled = delay_pair_en;
            end
            `MT_PDELAY_RESP, `MT_PDELAY_RESP_FU: begin
                is_response = 1'b1;
                pair_enabled = pdelay_pair_en;
            end
            default: begin
                is_request = 1'b0;
            end
        endcase
    end

    // ****************************************************
    // Verdict
    // ****************************************************
    wire version_ok = (s1_version_r == expected_version);
    // Disabled domain check ignores the field
    wire domain_ok = !domain_check_en || (s1_domain_r == expected_domain_number);
    wire no_master_hit = no_master_drop_en && !bmc_known_in &&
        (s1_type_r == `MT_SYNC || s1_type_r == `MT_FOLLOW_UP ||
        s1_type_r == `MT_DELAY_REQ);
    wire pair_ok = tbl_valid && (tbl_key == s1_key);
    wire pair_fail = is_response && pair_enabled && !pair_ok;
    wire drop_nxt = !version_ok || !domain_ok || no_master_hit || pair_fail;

    // Only accepted requests are remembered for later pairing
    always @* begin
        tbl_wr = s1_valid_r && is_request && version_ok && domain_ok && !no_master_hit;
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            verdict_valid_out <= 1'b0;
            fwd_host_out <= 1'b0;
            drop_out <= 1'b0;
            ts_capture_out <= 1'b0;
        end else if (ce_in) begin
            verdict_valid_out <= s1_valid_r;
            fwd_host_out <= s1_valid_r && !drop_nxt;
            drop_out <= s1_valid_r && drop_nxt;
            ts_capture_out <= s1_valid_r && version_ok && domain_ok;
        end
    end

    // Saturating count of dropped messages
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            drop_count_r <= 16'h0000;
        end else if (ce_in && s1_valid_r && drop_nxt && drop_count_r != 16'hffff) begin
            drop_count_r <= drop_count_r + 16'h0001;
        end
    end

    // ****************************************************
    // Egress checksum
    // ****************************************************
    reg cs_ipv6_r;
    reg cs_mod_r;
    reg [15:0] cs_old_r;
    reg [15:0] cs_oldw_r;
    reg [15:0] cs_neww_r;

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_ipv6_r <= 1'b0;
            cs_mod_r <= 1'b0;
            cs_old_r <= 16'h0000;
            cs_oldw_r <= 16'h0000;
            cs_neww_r <= 16'h0000;
        end else if (ce_in && msg_valid_in) begin
            cs_ipv6_r <= msg_is_ipv6_in;
            cs_mod_r <= msg_modified_in;
            cs_old_r <= msg_csum_in;
            cs_oldw_r <= msg_old_word_in;
            cs_neww_r <= msg_new_word_in;
        end
    end

    udp_csum_update u_csum (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .load_in(s1_valid_r),
        .is_ipv6_in(cs_ipv6_r),
        .modified_in(cs_mod_r),
        .csum_enable_in(csum_enable),
        .old_csum_in(cs_old_r),
        .old_word_in(cs_oldw_r),
        .new_word_in(cs_neww_r),
        .csum_out(csum_out)
    );

endmodule
`default_nettype wire

// ==== ptp_message_filter_config_checker.sv ====
// Port-level assertions for the PTP message filter
`timescale 1ns/1ns
`default_nettype none
`include "ptp_filter_regs.vh"
module ptp_message_filter_config_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    // Register port
    input wire logic [11:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // Message and verdict
    input wire logic bmc_known_in,
    input wire logic msg_valid_in,
    input wire logic [3:0] msg_type_in,
    input wire logic [3:0] msg_version_in,
    input wire logic [7:0] msg_domain_in,
    input wire logic msg_is_ipv6_in,
    input wire logic msg_modified_in,
    input wire logic [15:0] msg_csum_in,
    input wire logic verdict_valid_out,
    input wire logic fwd_host_out,
    input wire logic drop_out,
    input wire logic ts_capture_out,
    input wire logic [15:0] csum_out
);
    logic [15:0] cfg_r;
    logic [15:0] dv_r;
    logic ver_ok;
    logic cap_ok;
    logic nm_type;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    assign ver_ok = msg_version_in == dv_r[11:8];
    assign cap_ok = ver_ok && (!cfg_r[4] || msg_domain_in == dv_r[7:0]);
    assign nm_type = msg_type_in == `MT_SYNC || msg_type_in == `MT_FOLLOW_UP
        || msg_type_in == `MT_DELAY_REQ;
    // ****************
    // Shadow of the configuration
    // ****************
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_r <= `RST_MSG_CONFIG_TWO;
            dv_r <= `RST_DOMAIN_VERSION;
        end else if (ce_in && reg_wr_in && reg_addr_in == `OFS_MSG_CONFIG_TWO) begin
            cfg_r <= reg_wdata_in & `MASK_MSG_CONFIG_TWO;
        end else if (ce_in && reg_wr_in && reg_addr_in == `OFS_DOMAIN_VERSION) begin
            dv_r <= reg_wdata_in & `MASK_DOMAIN_VERSION;
        end
    end
    sequence s_msg(cond);
        msg_valid_in && ce_in && cond ##1 ce_in;
    endsequence
    sequence s_nomaster;
        msg_valid_in && ce_in && cfg_r[5] && nm_type ##1 ce_in && !bmc_known_in;
    endsequence
    // ****************
    // Checks
    // ****************
    chk_verdict_latency: assert property (s_msg(1'b1) |=> verdict_valid_out)
        else $error("verdict late");
    chk_single_outcome: assert property (
        verdict_valid_out |-> fwd_host_out != drop_out) else $error("fwd and drop clash");
    chk_version_drop: assert property (
        s_msg(!ver_ok) |=> drop_out && !ts_capture_out) else $error("bad version kept");
    chk_capture_flag: assert property (
        s_msg(1'b1) |=> ts_capture_out == $past(cap_ok, 2)) else $error("capture flag wrong");
    chk_domain_drop: assert property (
        s_msg(cfg_r[4] && msg_domain_in != dv_r[7:0]) |=> drop_out) else $error("domain kept");
    chk_domain_ignored: assert property (
        s_msg(!cfg_r[4] && ver_ok && msg_type_in == 4'hb) |=> fwd_host_out)
        else $error("domain not ignored");
    chk_no_master: assert property (s_nomaster |=> drop_out)
        else $error("no-master drop missed");
    chk_zero_csum: assert property (
        s_msg(!msg_is_ipv6_in && msg_csum_in == 16'h0000) |=> csum_out == 16'h0000)
        else $error("zero checksum changed");
    chk_csum_cleared: assert property (
        s_msg(!msg_is_ipv6_in && msg_modified_in && !cfg_r[2]) |=> csum_out == 16'h0000)
        else $error("checksum not zeroed");
    chk_cfg_readback: assert property (
        ce_in && reg_rd_in && reg_addr_in == `OFS_MSG_CONFIG_TWO |=> reg_rdata_out == $past(cfg_r))
        else $error("config readback wrong");
endmodule
`default_nettype wire

// ==== ptp_port_model.sv ====
// Switch-port model handing parsed PTP headers to the filter
`timescale 1ns/1ns
`default_nettype none
module ptp_port_model (
    // Clock
    input wire logic clk_in,
    // Header toward the filter
    output var logic valid_out,
    output var logic [97:0] hdr_out
);
    initial begin
        valid_out = 1'b0;
        hdr_out = 98'h0;
    end
    // One header after a gap, fields scrambled once released
    task send(input logic [97:0] h, input int gap);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        valid_out <= 1'b1;
        hdr_out <= h;
        @(posedge clk_in);
        valid_out <= 1'b0;
        hdr_out <= ~h;
    endtask
endmodule
`default_nettype wire

// ==== tb_ptp_message_filter_config.sv ====
// Self-checking bench for the PTP message filter
`timescale 1ns/1ns
`default_nettype none
`include "ptp_filter_regs.vh"
module tb_ptp_message_filter_config;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [11:0] reg_addr_in = 12'h000;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic bmc_known_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic verdict_valid_out;
    logic fwd_host_out;
    logic drop_out;
    logic ts_capture_out;
    logic [15:0] csum_out;
    logic hvalid;
    logic [97:0] hdr;
    logic [49:0] ck = 50'h0;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int i;
    int j;
    logic [3:0] nm [3] = '{`MT_SYNC, `MT_FOLLOW_UP, `MT_DELAY_REQ};
    // Type, domain, seq, source, forward
    logic [31:0] pt [12] = '{32'h000a0701, 32'h800a0701, 32'h800b0700, 32'h800a0800,
        32'h10140701, 32'h90140701, 32'h90140900, 32'h201e0701, 32'h301e0701,
        32'ha01e0701, 32'h311e0700, 32'h301f0700};
    // Enable, ipv6, modified, checksum in, checksum out
    logic [43:0] cs [6] = '{44'h10112341233, 44'h00112340000, 44'h10100000000,
        44'h00100000000, 44'h01112341233, 44'h10012341234};
    ptp_message_filter_config u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .bmc_known_in(bmc_known_in),
        .msg_valid_in(hvalid), .msg_type_in(hdr[97:94]), .msg_version_in(hdr[93:90]),
        .msg_domain_in(hdr[89:82]), .msg_seq_in(hdr[81:66]), .msg_src_port_in(hdr[65:50]),
        .msg_is_ipv6_in(hdr[49]), .msg_modified_in(hdr[48]), .msg_csum_in(hdr[47:32]),
        .msg_old_word_in(hdr[31:16]), .msg_new_word_in(hdr[15:0]),
        .verdict_valid_out(verdict_valid_out), .fwd_host_out(fwd_host_out),
        .drop_out(drop_out), .ts_capture_out(ts_capture_out), .csum_out(csum_out)
    );
    ptp_port_model u_src (.clk_in(clk_in), .valid_out(hvalid), .hdr_out(hdr));
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            complete_run();
        end
    end
    task complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_verdict(input logic f, input logic t);
        comparisons++;
        if ({verdict_valid_out, fwd_host_out, drop_out, ts_capture_out} !== {1'b1, f, !f, t}) begin
            n_fail++;
            $display("mismatch at %0t: verdict %b", $time, {fwd_host_out, drop_out});
        end
    endtask
    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk_word(reg_rdata_out, e);
    endtask
    // Header sent, then settle into the verdict cycle
    task msg(input logic [3:0] t, input logic [3:0] v, input logic [7:0] d,
        input logic [15:0] s, input logic [15:0] p);
        u_src.send({t, v, d, s, p, ck}, i % 2);
        @(posedge clk_in);
        #1;
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(`OFS_MSG_CONFIG_TWO, 16'h1004);
        rd(`OFS_DOMAIN_VERSION, 16'h0200);
        wr(12'h51a, 16'hffff);
        rd(12'h51a, 16'h0000);
        wr(`OFS_MSG_CONFIG_TWO, 16'hffff);
        rd(`OFS_MSG_CONFIG_TWO, 16'h1fff);
        wr(`OFS_DOMAIN_VERSION, 16'hffff);
        rd(`OFS_DOMAIN_VERSION, 16'h0fff);
        @(posedge clk_in);
        ce_in <= 1'b0;
        wr(`OFS_MSG_CONFIG_TWO, 16'h0000);
        ce_in <= 1'b1;
        rd(`OFS_MSG_CONFIG_TWO, 16'h1fff);
        $display("test registers done");
        wr(`OFS_DOMAIN_VERSION, 16'h0200);
        wr(`OFS_MSG_CONFIG_TWO, 16'h1c4b);
        msg(4'hb, 4'h2, 8'h33, 16'h0000, 16'h0000);
        chk_verdict(1'b1, 1'b1);
        msg(4'hb, 4'h3, 8'h00, 16'h0000, 16'h0000);
        chk_verdict(1'b0, 1'b0);
        wr(`OFS_DOMAIN_VERSION, 16'h0205);
        wr(`OFS_MSG_CONFIG_TWO, 16'h0010);
        msg(4'hb, 4'h2, 8'h05, 16'h0000, 16'h0000);
        chk_verdict(1'b1, 1'b1);
        msg(4'hb, 4'h2, 8'h06, 16'h0000, 16'h0000);
        chk_verdict(1'b0, 1'b0);
        $display("test version and domain done");
        wr(`OFS_DOMAIN_VERSION, 16'h0200);
        wr(`OFS_MSG_CONFIG_TWO, 16'h0020);
        for (j = 0; j < 2; j++) begin
            @(posedge clk_in);
            bmc_known_in <= j[0];
            for (i = 0; i < 3; i++) begin
                msg(nm[i], 4'h2, 8'h00, 16'h0000, 16'h0000);
                chk_verdict(j[0], 1'b1);
            end
        end
        $display("test no master done");
        wr(`OFS_MSG_CONFIG_TWO, 16'h0384);
        for (i = 0; i < 12; i++) begin
            msg(pt[i][31:28], 4'h2, {4'h0, pt[i][27:24]}, {8'h00, pt[i][23:16]},
                {8'h00, pt[i][15:8]});
            chk_verdict(pt[i][0], 1'b1);
        end
        wr(`OFS_MSG_CONFIG_TWO, 16'h0004);
        msg(`MT_FOLLOW_UP, 4'h2, 8'h00, 16'h000b, 16'h0007);
        chk_verdict(1'b1, 1'b1);
        $display("test pairing done");
        for (i = 0; i < 6; i++) begin
            wr(`OFS_MSG_CONFIG_TWO, {13'h0000, cs[i][40], 2'h0});
            ck = {cs[i][36], cs[i][32], cs[i][31:16], 16'h0001, 16'h0002};
            msg(4'hb, 4'h2, 8'h00, 16'h0000, 16'h0000);
            chk_word(csum_out, cs[i][15:0]);
        end
        $display("test checksum done");
        rd(`OFS_DROP_COUNT, 16'h000a);
        complete_run();
    end
endmodule
bind ptp_message_filter_config ptp_message_filter_config_checker u_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .bmc_known_in(bmc_known_in), .msg_valid_in(msg_valid_in),
    .msg_type_in(msg_type_in), .msg_version_in(msg_version_in), .msg_domain_in(msg_domain_in),
    .msg_is_ipv6_in(msg_is_ipv6_in), .msg_modified_in(msg_modified_in),
    .msg_csum_in(msg_csum_in), .verdict_valid_out(verdict_valid_out),
    .fwd_host_out(fwd_host_out), .drop_out(drop_out), .ts_capture_out(ts_capture_out),
    .csum_out(csum_out)
);
`default_nettype wire

// ==== udp_csum_update.v ====
// Egress UDP checksum rewrite: incremental update, zeroing or pass-through
`timescale 1ns/1ns
`default_nettype none
`include "ptp_filter_regs.vh"

module udp_csum_update (
    // Clock and reset
    input wire clk_in,
    input wire sys_rst_in,
    input wire ce_in,
    // Frame data
    input wire load_in,
    input wire is_ipv6_in,
    input wire modified_in,
    input wire csum_enable_in,
    input wire [15:0] old_csum_in,
    input wire [15:0] old_word_in,
    input wire [15:0] new_word_in,
    // Result
    output reg [15:0] csum_out
);

    reg [15:0] updated;
    reg [15:0] csum_nxt;

    // Ones-complement 16-bit add with end-around carry
    function [15:0] oc_add;
        input [15:0] a;
        input [15:0] b;
        reg [16:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            oc_add = s[15:0] + {15'h0000, s[16]};
        end
    endfunction

    always @* begin
        updated = ~oc_add(oc_add(~old_csum_in, ~old_word_in), new_word_in);
        csum_nxt = old_csum_in;
        if (is_ipv6_in) begin
            csum_nxt = updated;
        end else if (old_csum_in == 16'h0000) begin
            csum_nxt = 16'h0000;
        end else if (modified_in) begin
            if (csum_enable_in) begin
                csum_nxt = updated;
            end else begin
                csum_nxt = 16'h0000;
            end
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            csum_out <= 16'h0000;
        end else if (ce_in && load_in) begin
            csum_out <= csum_nxt;
        end
    end

endmodule
`default_nettype wire
